// ===== design/sfr_space_decode_and_device_id.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_space_decode_and_device_id (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // core access request
   input  wire logic       acc_valid,
   input  wire logic       acc_indirect,
   input  wire logic       acc_write,
   input  wire logic       acc_bit,
   input  wire logic [7:0] acc_addr,
   input  wire logic [2:0] acc_bit_pos,
   // steering, one cycle after the request
   output logic            sfr_sel_reg,
   output logic            ram_sel_reg,
   output logic            bit_ok_reg,
   output logic            bit_refused_reg,
   output logic            id_hit_reg,
   output logic [7:0]      rd_data_reg,
   output logic            rd_bit_reg
);
   logic       hit_fam;
   logic       hit_der;
   logic       hit_rev;
   logic [7:0] d_fam;
   logic [7:0] d_der;
   logic [7:0] d_rev;
   logic       sfr_sel_next;
   logic       ram_sel_next;
   logic       bit_ok_next;
   logic       bit_refused_next;
   logic       id_hit_next;
   logic [7:0] rd_data_next;
   logic       rd_bit_next;
   logic       upper;
   logic       bit_capable;

   id_byte_cell #(.addr(sfr_id_pkg::family_id_addr), .value(sfr_id_pkg::family_id_value))
      u_fam (.sel_addr(acc_addr), .hit(hit_fam), .data(d_fam));
   id_byte_cell #(.addr(sfr_id_pkg::derivative_id_addr),
                  .value(sfr_id_pkg::derivative_id_value))
      u_der (.sel_addr(acc_addr), .hit(hit_der), .data(d_der));
   id_byte_cell #(.addr(sfr_id_pkg::revision_id_addr), .value(sfr_id_pkg::revision_id_value))
      u_rev (.sel_addr(acc_addr), .hit(hit_rev), .data(d_rev));

   always_comb begin
      upper            = (acc_addr >= sfr_id_pkg::sfr_base) && (acc_addr <= sfr_id_pkg::sfr_top);
      bit_capable      = (acc_addr[2:0] == sfr_id_pkg::bit_addr_low_mask);
      sfr_sel_next     = acc_valid && upper && !acc_indirect;
      ram_sel_next     = acc_valid && !(upper && !acc_indirect);
      bit_ok_next      = sfr_sel_next && acc_bit && bit_capable;
      bit_refused_next = sfr_sel_next && acc_bit && !bit_capable;
      id_hit_next      = sfr_sel_next && (hit_fam || hit_der || hit_rev);
      rd_data_next     = sfr_id_pkg::byte_zero;
      // writes only flag the hit; constants stay untouched
      if (sfr_sel_next && !acc_write) begin
         if (hit_fam) begin
            rd_data_next = d_fam;
         end else if (hit_der) begin
            rd_data_next = d_der;
         end else if (hit_rev) begin
            rd_data_next = d_rev;
         end
      end
      rd_bit_next = rd_data_next[acc_bit_pos];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_sel_reg     <= 1'b0;
         ram_sel_reg     <= 1'b0;
         bit_ok_reg      <= 1'b0;
         bit_refused_reg <= 1'b0;
         id_hit_reg      <= 1'b0;
         rd_data_reg     <= sfr_id_pkg::byte_zero;
         rd_bit_reg      <= 1'b0;
      end else begin
         sfr_sel_reg     <= sfr_sel_next;
         ram_sel_reg     <= ram_sel_next;
         bit_ok_reg      <= bit_ok_next;
         bit_refused_reg <= bit_refused_next;
         id_hit_reg      <= id_hit_next;
         rd_data_reg     <= rd_data_next;
         rd_bit_reg      <= rd_bit_next;
      end
   end

   // steering; antecedents come from the ports so a broken decode cannot hide
   sequence direct_upper;
      acc_valid && !acc_indirect && (acc_addr >= sfr_id_pkg::sfr_base);
   endsequence
   sequence direct_lower;
      acc_valid && !acc_indirect && (acc_addr < sfr_id_pkg::sfr_base);
   endsequence
   sequence indirect_any;
      acc_valid && acc_indirect;
   endsequence
   chk_direct_to_sfr: assert property (@(posedge clk) disable iff (rst)
      direct_upper |=> sfr_sel_reg && !ram_sel_reg)
      else $error("direct upper access not steered to registers");
   chk_lower_to_ram: assert property (@(posedge clk) disable iff (rst)
      direct_lower |=> ram_sel_reg && !sfr_sel_reg)
      else $error("direct lower access not steered to data RAM");
   chk_sel_exclusive: assert property (@(posedge clk) disable iff (rst)
      !(sfr_sel_reg && ram_sel_reg))
      else $error("access steered to both spaces");
   chk_indirect_to_ram: assert property (@(posedge clk) disable iff (rst)
      indirect_any |=> ram_sel_reg && !sfr_sel_reg)
      else $error("indirect access reached register space");
   chk_ram_no_id: assert property (@(posedge clk) disable iff (rst)
      indirect_any |=> !id_hit_reg && !bit_ok_reg && !bit_refused_reg && !rd_bit_reg
      && (rd_data_reg == sfr_id_pkg::byte_zero))
      else $error("indirect access answered from register space");
   chk_idle_quiet: assert property (@(posedge clk) disable iff (rst)
      !acc_valid |=> !sfr_sel_reg && !ram_sel_reg && !bit_ok_reg && !bit_refused_reg
      && !id_hit_reg && !rd_bit_reg && (rd_data_reg == sfr_id_pkg::byte_zero))
      else $error("outputs active without a request");
   // first sampled edge of reset may still see power-up values, so look one later
   chk_reset_quiet: assert property (@(posedge clk)
      rst ##1 rst |-> !sfr_sel_reg && !ram_sel_reg && !id_hit_reg && !rd_bit_reg
      && (rd_data_reg == sfr_id_pkg::byte_zero))
      else $error("outputs not cleared by reset");

   // bit access; only addresses ending in 0 or 8 carry bit addresses
   sequence bit_at_capable;
      acc_valid && !acc_indirect && acc_bit && (acc_addr >= sfr_id_pkg::sfr_base)
      && (acc_addr[2:0] == sfr_id_pkg::bit_addr_low_mask);
   endsequence
   sequence bit_at_byte_only;
      acc_valid && !acc_indirect && acc_bit && (acc_addr >= sfr_id_pkg::sfr_base)
      && (acc_addr[2:0] != sfr_id_pkg::bit_addr_low_mask);
   endsequence
   chk_bit_capable: assert property (@(posedge clk) disable iff (rst)
      bit_at_capable |=> bit_ok_reg && !bit_refused_reg)
      else $error("bit access refused at bit-capable address");
   chk_byte_only: assert property (@(posedge clk) disable iff (rst)
      bit_at_byte_only |=> bit_refused_reg && !bit_ok_reg)
      else $error("bit access allowed at byte-only address");
   chk_byte_no_bit: assert property (@(posedge clk) disable iff (rst)
      acc_valid && !acc_bit |=> !bit_ok_reg && !bit_refused_reg)
      else $error("bit status raised on a byte access");
   chk_bit_value: assert property (@(posedge clk) disable iff (rst)
      direct_upper |=> rd_bit_reg == rd_data_reg[$past(acc_bit_pos)])
      else $error("bit read disagrees with its byte");

   // identification bytes
   sequence read_fam;
      acc_valid && !acc_indirect && !acc_write && (acc_addr == sfr_id_pkg::family_id_addr);
   endsequence
   sequence read_der;
      acc_valid && !acc_indirect && !acc_write
      && (acc_addr == sfr_id_pkg::derivative_id_addr);
   endsequence
   sequence read_rev;
      acc_valid && !acc_indirect && !acc_write && (acc_addr == sfr_id_pkg::revision_id_addr);
   endsequence
   sequence plain_read;
      acc_valid && !acc_indirect && !acc_write && (acc_addr >= sfr_id_pkg::sfr_base)
      && (acc_addr != sfr_id_pkg::family_id_addr)
      && (acc_addr != sfr_id_pkg::derivative_id_addr)
      && (acc_addr != sfr_id_pkg::revision_id_addr);
   endsequence
   chk_family_read: assert property (@(posedge clk) disable iff (rst)
      read_fam |=> (rd_data_reg == sfr_id_pkg::family_id_value) && id_hit_reg)
      else $error("family byte read wrong");
   chk_deriv_read: assert property (@(posedge clk) disable iff (rst)
      read_der |=> (rd_data_reg == sfr_id_pkg::derivative_id_value) && id_hit_reg)
      else $error("derivative byte read wrong");
   chk_rev_bit_read: assert property (@(posedge clk) disable iff (rst)
      read_rev |=> (rd_data_reg == sfr_id_pkg::revision_id_value) && id_hit_reg
      && (rd_bit_reg == sfr_id_pkg::revision_id_value[$past(acc_bit_pos)]))
      else $error("revision byte read wrong");
   chk_plain_read_zero: assert property (@(posedge clk) disable iff (rst)
      plain_read |=> !id_hit_reg && (rd_data_reg == sfr_id_pkg::byte_zero))
      else $error("identification data on another register");

   // write protection; the bytes have no storage, so a write shows only as a hit
   sequence write_fam;
      acc_valid && !acc_indirect && acc_write && (acc_addr == sfr_id_pkg::family_id_addr);
   endsequence
   sequence write_der;
      acc_valid && !acc_indirect && acc_write
      && (acc_addr == sfr_id_pkg::derivative_id_addr);
   endsequence
   sequence write_rev;
      acc_valid && !acc_indirect && acc_write && (acc_addr == sfr_id_pkg::revision_id_addr);
   endsequence
   sequence id_write;
      acc_valid && !acc_indirect && acc_write
      && ((acc_addr == sfr_id_pkg::family_id_addr)
      || (acc_addr == sfr_id_pkg::derivative_id_addr)
      || (acc_addr == sfr_id_pkg::revision_id_addr));
   endsequence
   chk_id_write_quiet: assert property (@(posedge clk) disable iff (rst)
      id_write |=> id_hit_reg && (rd_data_reg == sfr_id_pkg::byte_zero))
      else $error("write to identification byte returned data");
   chk_write_no_data: assert property (@(posedge clk) disable iff (rst)
      acc_valid && acc_write |=> (rd_data_reg == sfr_id_pkg::byte_zero) && !rd_bit_reg)
      else $error("write access returned read data");
   chk_fam_after_write: assert property (@(posedge clk) disable iff (rst)
      write_fam ##1 read_fam |=> rd_data_reg == sfr_id_pkg::family_id_value)
      else $error("family byte changed by write");
   chk_der_after_write: assert property (@(posedge clk) disable iff (rst)
      write_der ##1 read_der |=> rd_data_reg == sfr_id_pkg::derivative_id_value)
      else $error("derivative byte changed by write");
   chk_rev_after_write: assert property (@(posedge clk) disable iff (rst)
      write_rev ##1 read_rev |=> rd_data_reg == sfr_id_pkg::revision_id_value)
      else $error("revision byte changed by write");

endmodule // sfr_space_decode_and_device_id
`default_nettype wire

// ===== design/sfr_id_pkg.sv
`default_nettype none
package sfr_id_pkg;
   // address space bounds
   localparam logic [7:0] sfr_base          = 8'h80;
   localparam logic [7:0] sfr_top           = 8'hFF;
   localparam logic [2:0] bit_addr_low_mask = 3'h0;
   // identification register offsets
   localparam logic [7:0] derivative_id_addr = 8'hAD;
   localparam logic [7:0] family_id_addr     = 8'hB5;
   localparam logic [7:0] revision_id_addr   = 8'hB6;
   // family and derivative codes are arbitrary; revision zero marks the first revision
   localparam logic [7:0] family_id_value     = 8'h5A;
   localparam logic [7:0] derivative_id_value = 8'h01;
   localparam logic [7:0] revision_id_value   = 8'h00;
   localparam logic [7:0] byte_zero           = 8'h00;
endpackage
`default_nettype wire

// ===== design/id_byte_cell.sv
`timescale 1ns/1ns
`default_nettype none
module id_byte_cell #(
   parameter logic [7:0] addr  = 8'h00,
   parameter logic [7:0] value = 8'h00
) (
   input  wire logic [7:0] sel_addr,
   output logic            hit,
   output logic [7:0]      data
);
   // read-only constant, no storage so writes cannot disturb it
   assign hit  = (sel_addr == addr);
   assign data = value;
endmodule // id_byte_cell
`default_nettype wire

// ===== verif/core_access_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_access_model (
   // clock
   input  wire logic       clk,
   // direct or indirect access toward the decoder
   output logic            valid,
   output logic            indirect,
   output logic            write,
   output logic            bit_acc,
   output logic [7:0]      addr,
   output logic [2:0]      bit_pos
);
   initial {valid, indirect, write, bit_acc, addr, bit_pos} = 15'h0000;
   // fields change just after an edge, one access per cycle
   task automatic issue(input logic [14:0] f);
      @(posedge clk);
      {valid, indirect, write, bit_acc, addr, bit_pos} <= f;
   endtask
endmodule // core_access_model
`default_nettype wire

// ===== verif/test_sfr_space_decode_and_device_id.sv
`timescale 1ns/1ns
`default_nettype none
module test_sfr_space_decode_and_device_id;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        v, ind, wr, bt, sfr, ram, ok, refd, hit, rbit;
   logic [7:0]  a, rdata, x;
   logic [2:0]  p;
   logic [13:0] exp_prev = 14'h0000;
   logic [7:0]  ids [3];
   int          fail_count = 0;
   int          cmp_count = 0;
   logic [31:0] r;
   core_access_model i_core_access_model (.clk(clk), .valid(v), .indirect(ind),
      .write(wr), .bit_acc(bt), .addr(a), .bit_pos(p));
   sfr_space_decode_and_device_id i_sfr_space_decode_and_device_id (.clk(clk), .rst(rst),
      .acc_valid(v), .acc_indirect(ind), .acc_write(wr), .acc_bit(bt), .acc_addr(a),
      .acc_bit_pos(p), .sfr_sel_reg(sfr), .ram_sel_reg(ram), .bit_ok_reg(ok),
      .bit_refused_reg(refd), .id_hit_reg(hit), .rd_data_reg(rdata), .rd_bit_reg(rbit));
   initial forever #50 clk = ~clk;
   function automatic logic [13:0] expect_out(input logic [14:0] f);
      logic       s;
      logic       h;
      logic [7:0] d;
      s = f[14] & !f[13] & f[10];
      h = s & (f[10:3] == ids[0] || f[10:3] == ids[1] || f[10:3] == ids[2]);
      d = !(h & !f[12]) ? 8'h00 : f[10:3] == ids[0] ? sfr_id_pkg::family_id_value :
         f[10:3] == ids[1] ? sfr_id_pkg::derivative_id_value : sfr_id_pkg::revision_id_value;
      return {s, f[14] & !s, s & f[11] & f[5:3] == sfr_id_pkg::bit_addr_low_mask,
         s & f[11] & f[5:3] != sfr_id_pkg::bit_addr_low_mask, h, d, d[f[2:0]]};
   endfunction
   // pipelined: the answer of one access is judged while the next is issued
   task automatic step(input logic [14:0] f);
      i_core_access_model.issue(f);
      @(negedge clk);
      cmp_count++;
      if ({sfr, ram, ok, refd, hit, rdata, rbit} !== exp_prev) begin
         fail_count++;
         $display("MISMATCH %0t steering or read data wrong", $time);
      end
      exp_prev = expect_out(f);
   endtask
   task automatic end_sim;
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      ids = '{sfr_id_pkg::family_id_addr, sfr_id_pkg::derivative_id_addr,
         sfr_id_pkg::revision_id_addr};
      void'($urandom(48519));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) step({4'b1000, ids[i], 3'h7});
      for (int i = 0; i < 3; i++) begin
         step({4'b1010, ids[i], 3'h0});
         step({4'b1000, ids[i], 3'h1});
      end
      step({4'b1100, ids[0], 3'h0});
      step({4'b1001, 8'hB8, 3'h5});
      step({4'b1001, ids[0], 3'h2});
      step({4'b1000, 8'h7F, 3'h0});
      step({4'b1000, 8'h80, 3'h0});
      step({4'b1000, ids[0], 3'h3});
      // reset lands on a pending answer and must clear it
      i_core_access_model.issue(15'h0000);
      rst <= 1'b1;
      @(negedge clk);
      cmp_count++;
      if ({sfr, ram, ok, refd, hit, rdata, rbit} !== 14'h0000) begin
         fail_count++;
         $display("MISMATCH %0t outputs not cleared by reset", $time);
      end
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      exp_prev = 14'h0000;
      for (int i = 0; i < 300; i++) begin
         r = $urandom;
         x = r[3] ? {1'b0, r[14:8]} : r[4] ? {1'b1, r[11:8], 3'h0} : ids[r[9:8] % 3];
         step({r[5] | r[6], r[0], r[1], r[2], r[0] ? r[15:8] : x, r[18:16]});
      end
      step(15'h0000);
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_sim();
   end
endmodule // test_sfr_space_decode_and_device_id
`default_nettype wire
